// ---- filter_port_pkg.sv ----
// constants and types shared by the configuration port ends
//
// How it works
// - eight byte registers, 3-bit select, 8-bit bus
// - write strobe fall stores byte to register
// - host holds address and data at fall
// - read fall drives register until strobe rises
// - host holds address through whole read
// - host never lowers both strobes together
// - config bits 2-0 pick halfband stages
// - config bit 3 enables the filter
// - config bit 4 enables coefficient reads
// - config bits 7-5 FIR decimation, 0=8
// - tap count register, zero means 256
// - coefficients loaded by repeated port writes
// - input word length 8 to 24
// - input number system and bit order
// - bit clock divide 1-32, output order
// - output word width 8-32, zero=32
// - output rounding and number system bits
// - output gain bit doubles data
// - symmetry code in bits 1-0
// - mix factor word length 8 to 24
// - mix source and serial order bits
// - four bytes per word, pointer halts 128
// - read enable resets read pointer, sequential reads
package filter_port_pkg;

	// register indices on register_select
	localparam logic [2:0] REG_FILTER_CONFIGURATION = 3'h0;
	localparam logic [2:0] REG_FIR_TAP_COUNT        = 3'h1;
	localparam logic [2:0] REG_COEFFICIENT_PORT     = 3'h2;
	localparam logic [2:0] REG_INPUT_WORD_FORMAT    = 3'h3;
	localparam logic [2:0] REG_OUTPUT_BIT_TIMING    = 3'h4;
	localparam logic [2:0] REG_OUTPUT_WORD_FORMAT   = 3'h5;
	localparam logic [2:0] REG_COEFFICIENT_SYMMETRY = 3'h6;
	localparam logic [2:0] REG_MIX_WORD_FORMAT      = 3'h7;
	localparam int         REG_COUNT                = 8;
	localparam logic [7:0] REG_RESET                = 8'h00;

	// field positions
	localparam int CFG_HB_LSB     = 0;
	localparam int CFG_ENABLE_BIT = 3;
	localparam int CFG_RDEN_BIT   = 4;
	localparam int CFG_DEC_LSB    = 5;
	localparam int LEN_LSB        = 0;
	localparam int FMT_BIT5       = 5;
	localparam int FMT_BIT6       = 6;
	localparam int FMT_BIT7       = 7;
	localparam int SYM_LSB        = 0;

	// field codes and limits
	localparam logic [2:0] HB_MAX       = 3'h5;
	localparam logic [4:0] WORD_LEN_MIN = 5'h08;
	localparam logic [4:0] WORD_LEN_MAX = 5'h18;
	localparam logic [4:0] OUT_LEN_MIN  = 5'h08;
	localparam logic [7:0] TAP_MIN      = 8'h04;
	localparam logic [1:0] SYM_EVEN     = 2'h0;
	localparam logic [1:0] SYM_NONE     = 2'h1;
	localparam logic [1:0] SYM_ODD      = 2'h2;
	localparam logic [5:0] SYM_RSVD     = 6'h00;

	// coefficient storage
	localparam int         COEF_DEPTH     = 128;
	localparam logic [7:0] COEF_LAST      = 8'h80;
	localparam logic [1:0] COEF_LAST_BYTE = 2'h3;

	// pin sampling and host strobe timing, in core_clk cycles
	localparam int         SYNC_STAGES    = 3;
	localparam logic [3:0] HOST_SETUP_CYC = 4'h4;
	localparam logic [3:0] HOST_LOW_CYC   = 4'h8;
	localparam logic [3:0] HOST_RECOV_CYC = 4'h8;
	localparam logic [7:0] BUS_IDLE       = 8'hff;

	// decoded configuration handed to the datapath
	typedef struct packed {
		logic [2:0] halfband_stage;
		logic       filter_enable;
		logic       coef_read_enable;
		logic [3:0] fir_decimation;
		logic [8:0] tap_count;
		logic [4:0] in_length;
		logic       in_offset_binary;
		logic       in_msb_first;
		logic [5:0] bit_clock_div;
		logic       out_msb_first;
		logic [5:0] out_length;
		logic       out_round;
		logic       out_offset_binary;
		logic       out_gain_two;
		logic [1:0] symmetry;
		logic [4:0] mix_length;
		logic       mix_msb_first;
		logic       mix_serial;
		logic       config_error;
	} cfg_type;

	// host sequencer states
	typedef enum logic [3:0] {
		H_IDLE   = 4'b0001,
		H_SETUP  = 4'b0010,
		H_STROBE = 4'b0100,
		H_RECOV  = 4'b1000
	} host_state_type;

endpackage

// ---- filter_port_if.sv ----
// parallel configuration port between host and filter device
`timescale 1ns/1ps
interface filter_port_if;
	logic [2:0] register_select;
	logic       wr_n;
	logic       rd_n;
	logic [7:0] host_data;
	logic       host_oe_n;
	logic [7:0] dev_data;
	logic       dev_oe_n;
	logic [7:0] config_bus;

	// resolved level of the shared config_bus, pulled high when idle
	assign config_bus = !dev_oe_n ? dev_data :
	                    (!host_oe_n ? host_data : filter_port_pkg::BUS_IDLE);

	modport device (
		input  register_select,
		input  wr_n,
		input  rd_n,
		input  config_bus,
		output dev_data,
		output dev_oe_n
	);

	modport host (
		output register_select,
		output wr_n,
		output rd_n,
		output host_data,
		output host_oe_n,
		input  config_bus
	);
endinterface // filter_port_if

// ---- filter_port_device.sv ----
// filter device end: configuration registers and coefficient storage
`timescale 1ns/1ps
module filter_port_device (
	input  wire logic                     core_clk,
	input  wire logic                     rst,
	filter_port_if.device                 bus,
	input  wire logic [6:0]               coef_index,
	output logic      [31:0]              coef_word,
	output filter_port_pkg::cfg_type      cfg
);

	typedef struct packed {
		logic [2:0]                              wr_sync;
		logic [2:0]                              rd_sync;
		logic [2:0][2:0]                         addr_sync;
		logic [2:0][7:0]                         data_sync;
		logic                                    wr_lvl;
		logic                                    rd_lvl;
		logic [filter_port_pkg::REG_COUNT-1:0][7:0] regs;
		logic [filter_port_pkg::COEF_DEPTH-1:0][31:0] mem;
		logic [23:0]                             hold;
		logic [1:0]                              byte_cnt;
		logic [7:0]                              wptr;
		logic [8:0]                              rptr;
		logic [7:0]                              rd_data;
		logic                                    drive;
		logic [31:0]                             coef_q;
		filter_port_pkg::cfg_type                cfg;
	} dev_state_type;

	dev_state_type st_r;
	dev_state_type st_nxt;

	////////////////////////////////////////////////////////////////////////////
	// decoding helpers

	// word length code inside the legal 8..24 window
	function automatic logic len_ok(input logic [4:0] code);
		len_ok = (code >= filter_port_pkg::WORD_LEN_MIN) &&
		         (code <= filter_port_pkg::WORD_LEN_MAX);
	endfunction

	// five-bit count where zero stands for 32
	function automatic logic [5:0] zero_is_max(input logic [4:0] code);
		zero_is_max = {(code == 5'h00), code};
	endfunction

	// byte lane of a stored coefficient
	function automatic logic [7:0] lane(input logic [31:0] w, input logic [1:0] sel);
		lane = w[{sel, 3'h0} +: 8];
	endfunction

	// register image to datapath configuration
	function automatic filter_port_pkg::cfg_type decode(
		input logic [filter_port_pkg::REG_COUNT-1:0][7:0] r);
		filter_port_pkg::cfg_type c;
		logic [7:0] fc;
		logic [7:0] inf;
		logic [7:0] ot;
		logic [7:0] of;
		logic [7:0] sy;
		logic [7:0] mx;
		fc = r[filter_port_pkg::REG_FILTER_CONFIGURATION];
		inf = r[filter_port_pkg::REG_INPUT_WORD_FORMAT];
		ot = r[filter_port_pkg::REG_OUTPUT_BIT_TIMING];
		of = r[filter_port_pkg::REG_OUTPUT_WORD_FORMAT];
		sy = r[filter_port_pkg::REG_COEFFICIENT_SYMMETRY];
		mx = r[filter_port_pkg::REG_MIX_WORD_FORMAT];
		c.halfband_stage = fc[filter_port_pkg::CFG_HB_LSB +: 3];
		c.filter_enable = fc[filter_port_pkg::CFG_ENABLE_BIT];
		c.coef_read_enable = fc[filter_port_pkg::CFG_RDEN_BIT];
		c.fir_decimation = {(fc[filter_port_pkg::CFG_DEC_LSB +: 3] == 3'h0),
		                    fc[filter_port_pkg::CFG_DEC_LSB +: 3]};
		c.tap_count = {(r[filter_port_pkg::REG_FIR_TAP_COUNT] == 8'h00),
		               r[filter_port_pkg::REG_FIR_TAP_COUNT]};
		c.in_length = inf[filter_port_pkg::LEN_LSB +: 5];
		c.in_offset_binary = inf[filter_port_pkg::FMT_BIT5];
		c.in_msb_first = inf[filter_port_pkg::FMT_BIT6];
		c.bit_clock_div = zero_is_max(ot[filter_port_pkg::LEN_LSB +: 5]);
		c.out_msb_first = ot[filter_port_pkg::FMT_BIT5];
		c.out_length = zero_is_max(of[filter_port_pkg::LEN_LSB +: 5]);
		c.out_round = of[filter_port_pkg::FMT_BIT5];
		c.out_offset_binary = of[filter_port_pkg::FMT_BIT6];
		c.out_gain_two = of[filter_port_pkg::FMT_BIT7];
		c.symmetry = sy[filter_port_pkg::SYM_LSB +: 2];
		c.mix_length = mx[filter_port_pkg::LEN_LSB +: 5];
		c.mix_msb_first = mx[filter_port_pkg::FMT_BIT5];
		c.mix_serial = mx[filter_port_pkg::FMT_BIT6];
		// any code the datapath cannot honour
		c.config_error =
			(c.halfband_stage > filter_port_pkg::HB_MAX) ||
			((c.symmetry != filter_port_pkg::SYM_NONE) &&
			 (r[filter_port_pkg::REG_FIR_TAP_COUNT] != 8'h00) &&
			 (r[filter_port_pkg::REG_FIR_TAP_COUNT] < filter_port_pkg::TAP_MIN)) ||
			!len_ok(c.in_length) || !len_ok(c.mix_length) ||
			((of[filter_port_pkg::LEN_LSB +: 5] != 5'h00) &&
			 (of[filter_port_pkg::LEN_LSB +: 5] < filter_port_pkg::OUT_LEN_MIN)) ||
			(c.symmetry == 2'h3) ||
			(sy[7:2] != filter_port_pkg::SYM_RSVD);
		decode = c;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// next state

	logic       wr_fall;
	logic       rd_fall;
	logic       rd_rise;
	logic [2:0] sel;
	logic [7:0] din;
	logic       rden;

	// strobe edges count once the second and third stages agree
	always_comb begin
		wr_fall = st_r.wr_lvl && (st_r.wr_sync[1] == st_r.wr_sync[2]) && !st_r.wr_sync[2];
		rd_fall = st_r.rd_lvl && (st_r.rd_sync[1] == st_r.rd_sync[2]) && !st_r.rd_sync[2];
		rd_rise = !st_r.rd_lvl && (st_r.rd_sync[1] == st_r.rd_sync[2]) && st_r.rd_sync[2];
		sel = st_r.addr_sync[2];
		din = st_r.data_sync[2];
		rden = st_r.regs[filter_port_pkg::REG_FILTER_CONFIGURATION][filter_port_pkg::CFG_RDEN_BIT];
	end

	// register, pointer and bus driver updates
	always_comb begin
		st_nxt = st_r;
		st_nxt.wr_sync = {st_r.wr_sync[1:0], bus.wr_n};
		st_nxt.rd_sync = {st_r.rd_sync[1:0], bus.rd_n};
		st_nxt.addr_sync = {st_r.addr_sync[1:0], bus.register_select};
		st_nxt.data_sync = {st_r.data_sync[1:0], bus.config_bus};
		if (st_r.wr_sync[1] == st_r.wr_sync[2]) begin
			st_nxt.wr_lvl = st_r.wr_sync[2];
		end
		if (st_r.rd_sync[1] == st_r.rd_sync[2]) begin
			st_nxt.rd_lvl = st_r.rd_sync[2];
		end
		if (wr_fall) begin
			if (sel == filter_port_pkg::REG_COEFFICIENT_PORT) begin
				if (!rden && (st_r.wptr < filter_port_pkg::COEF_LAST)) begin
					if (st_r.byte_cnt == filter_port_pkg::COEF_LAST_BYTE) begin
						st_nxt.mem[st_r.wptr[6:0]] = {din, st_r.hold};
						st_nxt.wptr = st_r.wptr + 8'h01;
						st_nxt.byte_cnt = 2'h0;
					end else begin
						st_nxt.hold = {din, st_r.hold[23:8]};
						st_nxt.byte_cnt = st_r.byte_cnt + 2'h1;
					end
				end
			end else begin
				st_nxt.regs[sel] = din;
				st_nxt.wptr = 8'h00;
				st_nxt.byte_cnt = 2'h0;
				if ((sel == filter_port_pkg::REG_FILTER_CONFIGURATION) &&
				    din[filter_port_pkg::CFG_RDEN_BIT]) begin
					st_nxt.rptr = 9'h000;
				end
			end
		end
		// fetch and drive on read strobe fall
		if (rd_fall) begin
			st_nxt.drive = 1'b1;
			if (sel == filter_port_pkg::REG_COEFFICIENT_PORT) begin
				if (rden) begin
					st_nxt.rd_data = lane(st_r.mem[st_r.rptr[8:2]], st_r.rptr[1:0]);
					st_nxt.rptr = st_r.rptr + 9'h001;
				end else begin
					st_nxt.rd_data = 8'h00;
				end
			end else begin
				st_nxt.rd_data = st_r.regs[sel];
				st_nxt.wptr = 8'h00;
				st_nxt.byte_cnt = 2'h0;
			end
		end
		if (rd_rise) begin
			st_nxt.drive = 1'b0;
		end
		// datapath views, registered in the filter clock domain
		st_nxt.coef_q = st_r.mem[coef_index];
		st_nxt.cfg = decode(st_r.regs);
	end

	////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_r <= '0;
			st_r.wr_sync <= 3'h7;
			st_r.rd_sync <= 3'h7;
			st_r.wr_lvl <= 1'b1;
			st_r.rd_lvl <= 1'b1;
			st_r.regs <= {filter_port_pkg::REG_COUNT{filter_port_pkg::REG_RESET}};
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from state
	assign bus.dev_data = st_r.rd_data;
	assign bus.dev_oe_n = !st_r.drive;
	assign coef_word = st_r.coef_q;
	assign cfg = st_r.cfg;

endmodule // filter_port_device

// ---- filter_port_host.sv ----
// host end: turns single requests into strobed port cycles
`timescale 1ns/1ps
module filter_port_host (
	input  wire logic       core_clk,
	input  wire logic       rst,
	filter_port_if.host     bus,
	input  wire logic       req_valid,
	input  wire logic       req_write,
	input  wire logic [2:0] req_addr,
	input  wire logic [7:0] req_wdata,
	output logic            req_ready,
	output logic            rsp_valid,
	output logic [7:0]      rsp_data
);

	typedef struct packed {
		filter_port_pkg::host_state_type state;
		logic [3:0]                      cnt;
		logic                            write;
		logic [2:0]                      addr;
		logic [7:0]                      wdata;
		logic                            wr_n;
		logic                            rd_n;
		logic                            oe_n;
		logic                            rsp_valid;
		logic [7:0]                      rsp_data;
	} host_st_type;

	host_st_type st_r;
	host_st_type st_nxt;

	// sequencer: setup, strobe low, recovery
	always_comb begin
		st_nxt = st_r;
		st_nxt.rsp_valid = 1'b0;
		unique case (st_r.state)
			filter_port_pkg::H_IDLE: begin
				if (req_valid) begin
					// address and data set before strobe
					st_nxt.write = req_write;
					st_nxt.addr = req_addr;
					st_nxt.wdata = req_wdata;
					st_nxt.oe_n = !req_write;
					st_nxt.cnt = filter_port_pkg::HOST_SETUP_CYC - 4'h1;
					st_nxt.state = filter_port_pkg::H_SETUP;
				end
			end
			filter_port_pkg::H_SETUP: begin
				if (st_r.cnt == 4'h0) begin
					st_nxt.wr_n = !st_r.write;
					st_nxt.rd_n = st_r.write;
					st_nxt.cnt = filter_port_pkg::HOST_LOW_CYC - 4'h1;
					st_nxt.state = filter_port_pkg::H_STROBE;
				end else begin
					st_nxt.cnt = st_r.cnt - 4'h1;
				end
			end
			filter_port_pkg::H_STROBE: begin
				if (st_r.cnt == 4'h0) begin
					st_nxt.wr_n = 1'b1;
					st_nxt.rd_n = 1'b1;
					st_nxt.rsp_valid = 1'b1;
					st_nxt.rsp_data = st_r.write ? st_r.wdata : bus.config_bus;
					st_nxt.cnt = filter_port_pkg::HOST_RECOV_CYC - 4'h1;
					st_nxt.state = filter_port_pkg::H_RECOV;
				end else begin
					st_nxt.cnt = st_r.cnt - 4'h1;
				end
			end
			filter_port_pkg::H_RECOV: begin
				if (st_r.cnt == 4'h0) begin
					st_nxt.oe_n = 1'b1;
					st_nxt.state = filter_port_pkg::H_IDLE;
				end else begin
					st_nxt.cnt = st_r.cnt - 4'h1;
				end
			end
			default: begin
				st_nxt.state = filter_port_pkg::H_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_r <= '0;
			st_r.state <= filter_port_pkg::H_IDLE;
			st_r.wr_n <= 1'b1;
			st_r.rd_n <= 1'b1;
			st_r.oe_n <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// pins and user answers
	assign bus.register_select = st_r.addr;
	assign bus.wr_n = st_r.wr_n;
	assign bus.rd_n = st_r.rd_n;
	assign bus.host_data = st_r.wdata;
	assign bus.host_oe_n = st_r.oe_n;
	assign req_ready = (st_r.state == filter_port_pkg::H_IDLE);
	assign rsp_valid = st_r.rsp_valid;
	assign rsp_data = st_r.rsp_data;

endmodule // filter_port_host

// ---- filter_port_assertions.sv ----
// concurrent checks on the configuration port wire
`timescale 1ns/1ps
module filter_port_assertions (
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic [2:0] register_select,
	input wire logic       wr_n,
	input wire logic       rd_n,
	input wire logic       host_oe_n,
	input wire logic       dev_oe_n,
	input wire logic [7:0] config_bus
);

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////////////
	// strobe discipline from the host end
	strobes_exclusive_a: assert property (!(!wr_n && !rd_n))
		else $error("read and write strobes low together");
	read_addr_hold_a: assert property ((!rd_n && !$past(rd_n)) |-> $stable(register_select))
		else $error("register select moved during a read");
	write_setup_a: assert property ($fell(wr_n) |-> !host_oe_n &&
		config_bus == $past(config_bus, 3) && register_select == $past(register_select, 3))
		else $error("address or data not settled at write fall");
	write_low_width_a: assert property ($fell(wr_n) |-> !wr_n [*6])
		else $error("write strobe low too briefly");

	////////////////////////////////////////////////////////////////////////////////
	// bus drive by the device end
	read_drive_start_a: assert property ($fell(rd_n) |-> ##[1:6] !dev_oe_n)
		else $error("device did not drive after read fall");
	read_drive_hold_a: assert property ((!rd_n && !$past(rd_n, 6)) |-> !dev_oe_n)
		else $error("device released the bus during a read");
	read_release_a: assert property ($rose(rd_n) |-> ##[1:7] dev_oe_n)
		else $error("device kept driving after read rise");
	idle_bus_free_a: assert property ((rd_n && $past(rd_n, 7)) |-> dev_oe_n)
		else $error("device drives the bus outside a read");
	single_driver_a: assert property (!(!dev_oe_n && !host_oe_n))
		else $error("both ends drive the bus");

endmodule // filter_port_assertions

// ---- filter_config_register_port_bench.sv ----
// self-checking bench joining host and device ends of the port
`timescale 1ns/1ps
module filter_config_register_port_bench;
	logic                     core_clk  = 1'b0;
	logic                     rst       = 1'b1;
	logic                     req_valid = 1'b0;
	logic                     req_write = 1'b0;
	logic [2:0]               req_addr  = 3'h0;
	logic [7:0]               req_wdata = 8'h00;
	logic [6:0]               coef_index = 7'h00;
	logic                     req_ready;
	logic                     rsp_valid;
	logic [7:0]               rsp_data;
	logic [31:0]              coef_word;
	filter_port_pkg::cfg_type cfg;
	logic [7:0]               q;
	logic [7:0]               img [8] = '{8'ha5, 8'h04, 8'h00, 8'h58, 8'h3f, 8'hf8, 8'h02, 8'h58};
	int                       mismatches = 0;
	int                       cmp_count  = 0;

	filter_port_if port_bus ();

	filter_port_device i_filter_port_device (.core_clk(core_clk), .rst(rst), .bus(port_bus),
		.coef_index(coef_index), .coef_word(coef_word), .cfg(cfg));
	filter_port_host i_filter_port_host (.core_clk(core_clk), .rst(rst), .bus(port_bus),
		.req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
		.req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data));
	filter_port_assertions port_checker (.core_clk(core_clk), .rst(rst),
		.register_select(port_bus.register_select), .wr_n(port_bus.wr_n),
		.rd_n(port_bus.rd_n), .host_oe_n(port_bus.host_oe_n),
		.dev_oe_n(port_bus.dev_oe_n), .config_bus(port_bus.config_bus));

	// free running core clock
	always #5 core_clk = ~core_clk;

	////////////////////////////////////////////////////////////////////////////////
	// compare, report and close
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task stop_test;
		$display("mismatches %0d comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// one host request, waits for the answer pulse
	task xfer(input logic w, input logic [2:0] a, input logic [7:0] d);
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n < 40) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		req_valid = 1'b1;
		req_write = w;
		req_addr  = a;
		req_wdata = d;
		@(posedge core_clk);
		#1;
		req_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 40) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		check("answer pulse", {31'h0, rsp_valid}, 32'h1);
		q = rsp_data;
	endtask

	task rd(input logic [2:0] a, input logic [7:0] e);
		xfer(1'b0, a, 8'h00);
		check("read data", q, e);
	endtask

	task coef(input logic [6:0] i, input logic [31:0] e);
		coef_index = i;
		repeat (2) @(posedge core_clk);
		#1;
		check("coefficient word", coef_word, e);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (6) @(posedge core_clk);
		#1;
		rst = 1'b0;
		check("idle bus", port_bus.config_bus, 8'hff);
		for (int i = 0; i < 8; i++) rd(i[2:0], 8'h00);
		check("decimation", cfg.fir_decimation, 4'h8);
		check("taps", cfg.tap_count, 9'h100);
		check("bit clock", cfg.bit_clock_div, 6'h20);
		check("out width", cfg.out_length, 6'h20);
		check("config error", cfg.config_error, 1'b1);
		for (int i = 0; i < 8; i++) if (i != 2) xfer(1'b1, i[2:0], img[i]);
		for (int i = 0; i < 8; i++) if (i != 2) rd(i[2:0], img[i]);
		check("halfbands", cfg.halfband_stage, 3'h5);
		check("enable", cfg.filter_enable, 1'b0);
		check("decimation", cfg.fir_decimation, 4'h5);
		check("taps", cfg.tap_count, 9'h004);
		check("in length", cfg.in_length, 5'h18);
		check("in format", {cfg.in_offset_binary, cfg.in_msb_first}, 2'b01);
		check("bit clock", {cfg.out_msb_first, cfg.bit_clock_div}, 7'h5f);
		check("out width", cfg.out_length, 6'h18);
		check("rounding", {cfg.out_round, cfg.out_offset_binary}, 2'b11);
		check("gain", cfg.out_gain_two, 1'b1);
		check("symmetry", cfg.symmetry, 2'h2);
		check("mix length", cfg.mix_length, 5'h18);
		check("mix format", {cfg.mix_serial, cfg.mix_msb_first}, 2'b10);
		check("config error", cfg.config_error, 1'b0);
		xfer(1'b1, 3'h0, 8'h08);
		xfer(1'b1, 3'h3, 8'h28);
		xfer(1'b1, 3'h4, 8'h00);
		xfer(1'b1, 3'h5, 8'h00);
		xfer(1'b1, 3'h7, 8'h20);
		check("enable", {cfg.filter_enable, cfg.fir_decimation}, 5'h18);
		check("in format", {cfg.in_offset_binary, cfg.in_msb_first}, 2'b10);
		check("bit clock", {cfg.out_msb_first, cfg.bit_clock_div}, 7'h20);
		check("rounding", {cfg.out_round, cfg.out_offset_binary, cfg.out_gain_two}, 3'h0);
		check("mix format", {cfg.mix_serial, cfg.mix_msb_first}, 2'b01);
		check("config error", cfg.config_error, 1'b1);
		// invalid codes raise the error flag, legal ones clear it
		xfer(1'b1, 3'h7, 8'h58);
		check("config error", cfg.config_error, 1'b0);
		check("read enable", cfg.coef_read_enable, 1'b0);
		xfer(1'b1, 3'h0, 8'h0e);
		check("config error", cfg.config_error, 1'b1);
		xfer(1'b1, 3'h0, 8'h08);
		xfer(1'b1, 3'h1, 8'h03);
		check("config error", cfg.config_error, 1'b1);
		xfer(1'b1, 3'h6, 8'h01);
		check("symmetry", cfg.symmetry, 2'h1);
		check("config error", cfg.config_error, 1'b0);
		xfer(1'b1, 3'h6, 8'h03);
		check("config error", cfg.config_error, 1'b1);
		xfer(1'b1, 3'h6, 8'h06);
		check("config error", cfg.config_error, 1'b1);
		xfer(1'b1, 3'h6, 8'h02);
		xfer(1'b1, 3'h1, 8'h04);
		xfer(1'b1, 3'h5, 8'h07);
		check("config error", cfg.config_error, 1'b1);
		xfer(1'b1, 3'h5, 8'h08);
		check("out width", cfg.out_length, 6'h08);
		check("config error", cfg.config_error, 1'b0);
		// two whole words, then a partial word lost by another access
		for (int i = 0; i < 8; i++) xfer(1'b1, 3'h2, 8'h11 * (i + 1));
		coef(7'h00, 32'h44332211);
		coef(7'h01, 32'h88776655);
		xfer(1'b1, 3'h2, 8'h99);
		xfer(1'b1, 3'h2, 8'haa);
		rd(3'h1, 8'h04);
		for (int i = 0; i < 4; i++) xfer(1'b1, 3'h2, 8'h01 + i);
		coef(7'h00, 32'h04030201);
		coef(7'h01, 32'h88776655);
		// read enable blocks writes and replays bytes in order
		xfer(1'b1, 3'h0, 8'h18);
		check("read enable", cfg.coef_read_enable, 1'b1);
		for (int i = 0; i < 4; i++) xfer(1'b1, 3'h2, 8'hee);
		coef(7'h00, 32'h04030201);
		xfer(1'b1, 3'h0, 8'h18);
		for (int i = 0; i < 4; i++) rd(3'h2, 8'h01 + i);
		for (int i = 0; i < 4; i++) rd(3'h2, 8'h55 + 8'h11 * i);
		// fill past the last location, pointer must halt
		xfer(1'b1, 3'h0, 8'h08);
		for (int w = 0; w < 129; w++) begin
			for (int b = 0; b < 4; b++) begin
				xfer(1'b1, 3'h2, (b == 0) ? w[7:0] : ((b == 3) ? 8'h5a : 8'h00));
			end
		end
		coef(7'h00, 32'h5a000000);
		coef(7'h7f, 32'h5a00007f);
		stop_test();
	end

	// watchdog against a hung handshake
	initial begin
		repeat (40000) @(posedge core_clk);
		mismatches++;
		stop_test();
	end

endmodule // filter_config_register_port_bench
